// File: cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

	typedef logic [2:0]  mode_t;
	typedef logic [9:0]  idx_t;
	typedef logic [11:0] addr_t;

	// ************************************************************
	// register indices; byte address is four times the index
	// ************************************************************
	localparam idx_t  IDX_CMP_CTRL   = 10'h01f;
	localparam idx_t  IDX_IRQ_CTRL   = 10'h00b;
	localparam idx_t  IDX_FLAG       = 10'h00c;
	localparam idx_t  IDX_ENABLE     = 10'h08c;
	localparam idx_t  IDX_DIRECTION  = 10'h085;
	localparam idx_t  IDX_PORT_DATA  = 10'h005;
	localparam addr_t ADDR_CMP_CTRL  = {IDX_CMP_CTRL, 2'h0};
	localparam addr_t ADDR_IRQ_CTRL  = {IDX_IRQ_CTRL, 2'h0};
	localparam addr_t ADDR_FLAG      = {IDX_FLAG, 2'h0};
	localparam addr_t ADDR_ENABLE    = {IDX_ENABLE, 2'h0};
	localparam addr_t ADDR_DIRECTION = {IDX_DIRECTION, 2'h0};
	localparam addr_t ADDR_PORT_DATA = {IDX_PORT_DATA, 2'h0};

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_CMP2_RESULT = 7;
	localparam int BIT_CMP1_RESULT = 6;
	localparam int BIT_INPUT_SW    = 3;
	localparam int BIT_CHANGE_FLAG = 6;
	localparam int BIT_CHANGE_IEN  = 6;
	localparam int BIT_GLOBAL_IEN  = 7;
	localparam int BIT_PERIPH_IEN  = 6;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [3:0] RST_CMP_CTRL  = 4'h0;
	localparam logic [4:0] RST_DIRECTION = 5'h1f;
	localparam logic [4:0] RST_PORT_DATA = 5'h00;

	// ************************************************************
	// mode encodings
	// ************************************************************
	localparam mode_t MODE_RESET   = 3'h0;
	localparam mode_t MODE_MUX3    = 3'h1;
	localparam mode_t MODE_MUX4    = 3'h2;
	localparam mode_t MODE_COMREF  = 3'h3;
	localparam mode_t MODE_INDEP2  = 3'h4;
	localparam mode_t MODE_INDEP1  = 3'h5;
	localparam mode_t MODE_OUTPUTS = 3'h6;
	localparam mode_t MODE_OFF     = 3'h7;

	// lines 0..4 that a mode turns into analog inputs
	function automatic logic [4:0] analogMaskOf(input mode_t m);
		logic [4:0] r;
		r = 5'h00;
		unique case (m)
			MODE_RESET, MODE_MUX3, MODE_MUX4, MODE_INDEP2: r = 5'h0f;
			MODE_COMREF, MODE_OUTPUTS:                     r = 5'h07;
			MODE_INDEP1:                                   r = 5'h06;
			MODE_OFF:                                      r = 5'h00;
		endcase
		return r;
	endfunction

endpackage

// File: cmp_route_if.sv
`timescale 1ns/10ps
// carries mode and pin state between register logic and the mux
interface cmp_route_if;
	logic [2:0] mode;
	logic       inSwitch;
	logic [4:0] dirBits;
	logic [4:0] portLatch;
	logic [1:0] cmpRaw;
	logic [4:0] analogMask;
	logic [4:0] pinOut;
	logic [4:0] pinOe;
	logic       cmp1On;
	logic       cmp2On;
	logic       posUseVref;
	logic       cmp1NegLine3;
	logic       cmp2NegLine2;

	modport ctl (output mode, inSwitch, dirBits, portLatch, cmpRaw,
		input analogMask, pinOut, pinOe, cmp1On, cmp2On, posUseVref,
		cmp1NegLine3, cmp2NegLine2);
	modport mux (input mode, inSwitch, dirBits, portLatch, cmpRaw,
		output analogMask, pinOut, pinOe, cmp1On, cmp2On, posUseVref,
		cmp1NegLine3, cmp2NegLine2);
endinterface // cmp_route_if

// File: cmp_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser; only the second stage is visible
module cmp_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} state_s;

	state_s s_q;
	state_s s_d;

	// first stage feeds the second and nothing else
	always_comb begin
		s_d    = s_q;
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.s2;
endmodule // cmp_sync

// File: cmp_pin_mux.sv
`timescale 1ns/10ps
// fixed decode of the mode field into routing and pin drive
module cmp_pin_mux (
	cmp_route_if.mux rt
);
	always_comb begin
		rt.analogMask   = cmp_ctrl_pkg::analogMaskOf(rt.mode);
		// comparators are powered only in modes that use them
		rt.cmp1On       = !(rt.mode inside {cmp_ctrl_pkg::MODE_RESET,
			cmp_ctrl_pkg::MODE_OFF, cmp_ctrl_pkg::MODE_INDEP1});
		rt.cmp2On       = !(rt.mode inside {cmp_ctrl_pkg::MODE_RESET,
			cmp_ctrl_pkg::MODE_OFF});
		rt.posUseVref   = (rt.mode == cmp_ctrl_pkg::MODE_MUX4);
		rt.cmp1NegLine3 = rt.inSwitch &&
			(rt.mode inside {cmp_ctrl_pkg::MODE_MUX3,
			cmp_ctrl_pkg::MODE_MUX4});
		rt.cmp2NegLine2 = rt.inSwitch &&
			(rt.mode == cmp_ctrl_pkg::MODE_MUX4);
		// raw comparator levels bypass the port latch; no resync on purpose
		rt.pinOut = rt.portLatch;
		if (rt.mode == cmp_ctrl_pkg::MODE_OUTPUTS) begin
			rt.pinOut[3] = rt.cmpRaw[0];
			rt.pinOut[4] = rt.cmpRaw[1];
		end
		rt.pinOe = ~rt.dirBits;
	end
endmodule // cmp_pin_mux

// File: cmp_ctrl_top.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
// comparator control block with APB register access
module cmp_ctrl_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  cmpRawIn,
	input  wire logic [4:0]  pinIn,
	output logic      [4:0]  pinOut,
	output logic      [4:0]  pinOe,
	output logic             cmp1On,
	output logic             cmp2On,
	output logic             posUseVref,
	output logic             cmp1NegLine3,
	output logic             cmp2NegLine2,
	input  wire logic        sleepMode,
	output logic             wakeRequest,
	output logic             irqRequest
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0] rdata;
		logic [3:0] ctrl;
		logic       flag;
		logic       ien;
		logic       global_irq_en;
		logic       peripheral_irq_en;
		logic [4:0] dir;
		logic [4:0] port;
		logic [1:0] latch;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic [1:0] cmpSync;
	logic [4:0] pinSync;
	logic       setup;
	logic       access;
	logic       mapped;
	logic       mismatch;
	logic       ctrlAccess;

	cmp_route_if rt ();

	// ************************************************************
	// synchronisers and routing
	// ************************************************************
	cmp_sync #(.W(2)) uCmpSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     (cmpRawIn),
		.dout    (cmpSync)
	);

	cmp_sync #(.W(5)) uPinSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     (pinIn),
		.dout    (pinSync)
	);

	cmp_pin_mux uMux (
		.rt (rt.mux)
	);

	// mode and port state go out to the mux
	assign rt.mode      = s_q.ctrl[2:0];
	assign rt.inSwitch  = s_q.ctrl[cmp_ctrl_pkg::BIT_INPUT_SW];
	assign rt.dirBits   = s_q.dir;
	assign rt.portLatch = s_q.port;
	assign rt.cmpRaw    = cmpRawIn;

	assign pinOut       = rt.pinOut;
	assign pinOe        = rt.pinOe;
	assign cmp1On       = rt.cmp1On;
	assign cmp2On       = rt.cmp2On;
	assign posUseVref   = rt.posUseVref;
	assign cmp1NegLine3 = rt.cmp1NegLine3;
	assign cmp2NegLine2 = rt.cmp2NegLine2;

	// ************************************************************
	// bus decode
	// ************************************************************
	function automatic logic isMapped(input logic [11:0] a);
		return a inside {cmp_ctrl_pkg::ADDR_CMP_CTRL,
			cmp_ctrl_pkg::ADDR_IRQ_CTRL, cmp_ctrl_pkg::ADDR_FLAG,
			cmp_ctrl_pkg::ADDR_ENABLE, cmp_ctrl_pkg::ADDR_DIRECTION,
			cmp_ctrl_pkg::ADDR_PORT_DATA};
	endfunction

	// zero wait states; errors only on unmapped addresses
	assign setup      = psel && !penable;
	assign access     = psel && penable;
	assign mapped     = isMapped(paddr);
	assign pready     = 1'b1;
	assign pslverr    = access && !mapped;
	assign ctrlAccess = access && (paddr == cmp_ctrl_pkg::ADDR_CMP_CTRL);
	assign prdata     = {24'h000000, s_q.rdata};

	// live result differs from the copy taken at the last control access
	assign mismatch = (cmpSync != s_q.latch);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		// read data is captured in the setup cycle, so it is a flop
		if (setup && !pwrite) begin
			s_d.rdata = 8'h00;
			unique case (paddr)
				cmp_ctrl_pkg::ADDR_CMP_CTRL: begin
					s_d.rdata[cmp_ctrl_pkg::BIT_CMP2_RESULT] =
						cmpSync[1];
					s_d.rdata[cmp_ctrl_pkg::BIT_CMP1_RESULT] =
						cmpSync[0];
					s_d.rdata[3:0] = s_q.ctrl;
				end
				cmp_ctrl_pkg::ADDR_FLAG:
					s_d.rdata[cmp_ctrl_pkg::BIT_CHANGE_FLAG] = s_q.flag;
				cmp_ctrl_pkg::ADDR_ENABLE:
					s_d.rdata[cmp_ctrl_pkg::BIT_CHANGE_IEN] = s_q.ien;
				cmp_ctrl_pkg::ADDR_IRQ_CTRL: begin
					s_d.rdata[cmp_ctrl_pkg::BIT_GLOBAL_IEN] = s_q.global_irq_en;
					s_d.rdata[cmp_ctrl_pkg::BIT_PERIPH_IEN] = s_q.peripheral_irq_en;
				end
				cmp_ctrl_pkg::ADDR_DIRECTION:
					s_d.rdata[4:0] = s_q.dir;
				cmp_ctrl_pkg::ADDR_PORT_DATA:
					s_d.rdata[4:0] = pinSync & ~rt.analogMask;
				default:
					s_d.rdata = 8'h00;
			endcase
		end
		// writes take effect at the access edge
		if (access && pwrite) begin
			unique case (paddr)
				cmp_ctrl_pkg::ADDR_CMP_CTRL:
					s_d.ctrl = pwdata[3:0];
				cmp_ctrl_pkg::ADDR_FLAG:
					s_d.flag = pwdata[cmp_ctrl_pkg::BIT_CHANGE_FLAG];
				cmp_ctrl_pkg::ADDR_ENABLE:
					s_d.ien = pwdata[cmp_ctrl_pkg::BIT_CHANGE_IEN];
				cmp_ctrl_pkg::ADDR_IRQ_CTRL: begin
					s_d.global_irq_en  = pwdata[cmp_ctrl_pkg::BIT_GLOBAL_IEN];
					s_d.peripheral_irq_en = pwdata[cmp_ctrl_pkg::BIT_PERIPH_IEN];
				end
				cmp_ctrl_pkg::ADDR_DIRECTION:
					s_d.dir = pwdata[4:0];
				cmp_ctrl_pkg::ADDR_PORT_DATA:
					s_d.port = pwdata[4:0];
				default:
					s_d.dir = s_q.dir;
			endcase
		end
		// any control access, read or write, reloads the copy
		if (ctrlAccess) begin
			s_d.latch = cmpSync;
		end
		// compare still uses the old copy here, so a change that lands
		// on the access cycle is not lost set beats a clear
		if (mismatch) begin
			s_d.flag = 1'b1;
		end
	end

	// sleep never touches the registers, only reset does
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q       <= '0;
			s_q.ctrl  <= cmp_ctrl_pkg::RST_CMP_CTRL;
			s_q.dir   <= cmp_ctrl_pkg::RST_DIRECTION;
			s_q.port  <= cmp_ctrl_pkg::RST_PORT_DATA;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// interrupt and wake
	// ************************************************************
	assign irqRequest  = s_q.flag && s_q.ien && s_q.peripheral_irq_en && s_q.global_irq_en;
	// wake ignores the global enables, as the core does while asleep
	assign wakeRequest = sleepMode && s_q.flag && s_q.ien;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence readCtrlSeq;
		setup && !pwrite && paddr == cmp_ctrl_pkg::ADDR_CMP_CTRL
		##1 access && !pwrite && paddr == cmp_ctrl_pkg::ADDR_CMP_CTRL;
	endsequence

	sequence stableAfterAccess;
		ctrlAccess ##1 $stable(cmpSync);
	endsequence

	sequence ctrlWriteSeq;
		access && pwrite && paddr == cmp_ctrl_pkg::ADDR_CMP_CTRL;
	endsequence

	a_result_bits: assert property (
		readCtrlSeq |-> prdata[7:6] == $past(cmpSync))
		else $error("result bits differ from synchronised outputs");

	a_upper_zero: assert property (
		readCtrlSeq |-> prdata[5:4] == 2'h0 && prdata[31:8] == 24'h0)
		else $error("unimplemented control bits not zero");

	a_flag_on_change: assert property (
		mismatch |=> s_q.flag)
		else $error("change flag not set on mismatch");

	a_flag_sw_clear: assert property (
		access && pwrite && paddr == cmp_ctrl_pkg::ADDR_FLAG &&
		!pwdata[6] && !mismatch |=> !s_q.flag)
		else $error("flag not cleared by write of zero");

	a_mismatch_ends: assert property (
		stableAfterAccess |-> !mismatch)
		else $error("mismatch survives control access");

	a_irq_gating: assert property (
		access && pwrite && paddr == cmp_ctrl_pkg::ADDR_IRQ_CTRL &&
		!pwdata[cmp_ctrl_pkg::BIT_GLOBAL_IEN] |=> !irqRequest)
		else $error("interrupt request gating wrong");

	a_ctrl_hold: assert property (
		!(access && pwrite && paddr == cmp_ctrl_pkg::ADDR_CMP_CTRL)
		|=> $stable(s_q.ctrl))
		else $error("control register changed without a write");

	a_off_mode: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_OFF |-> !cmp1On && !cmp2On)
		else $error("comparators powered in off mode");

	a_vref_mode: assert property (
		ctrlWriteSeq |=> posUseVref ==
		($past(pwdata[2:0]) == cmp_ctrl_pkg::MODE_MUX4))
		else $error("reference routing wrong");

	a_sw_route: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_MUX3 |->
		cmp1NegLine3 == s_q.ctrl[3] && !cmp2NegLine2)
		else $error("input switch routing wrong in mode 001");

	a_out_mux: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_OUTPUTS |->
		pinOut[4:3] == cmpRawIn && pinOe == ~s_q.dir)
		else $error("comparator outputs not on lines 3 and 4");

	a_analog_read: assert property (
		setup && !pwrite && paddr == cmp_ctrl_pkg::ADDR_PORT_DATA
		|=> (prdata[4:0] & $past(rt.analogMask)) == 5'h00)
		else $error("analog line read as nonzero");

	// ************************************************************
	// flag, interrupt and wake checks
	// ************************************************************
	// a write of one raises the flag even with no comparator change
	a_flag_sw_set: assert property (
		access && pwrite && paddr == cmp_ctrl_pkg::ADDR_FLAG &&
		pwdata[cmp_ctrl_pkg::BIT_CHANGE_FLAG] |=> s_q.flag)
		else $error("flag not set by write of one");

	// the flag only drops through a software write
	a_flag_hold: assert property (
		s_q.flag &&
		!(access && pwrite && paddr == cmp_ctrl_pkg::ADDR_FLAG)
		|=> s_q.flag)
		else $error("change flag fell without a write");

	a_irq_raise: assert property (
		access && pwrite && paddr == cmp_ctrl_pkg::ADDR_FLAG &&
		pwdata[cmp_ctrl_pkg::BIT_CHANGE_FLAG] &&
		s_q.ien && s_q.peripheral_irq_en && s_q.global_irq_en |=> irqRequest)
		else $error("interrupt not raised with all enables set");

	// sleep may end in the same cycle, and so may the enable
	a_wake_path: assert property (
		sleepMode && mismatch && s_q.ien
		|=> wakeRequest || !sleepMode || !s_q.ien)
		else $error("comparator change did not wake the core");

	a_wake_awake: assert property (
		!sleepMode |-> !wakeRequest)
		else $error("wake requested while awake");

	// the copy must hold what was live at the access edge
	a_latch_reload: assert property (
		ctrlAccess |=> s_q.latch == $past(cmpSync))
		else $error("result copy not reloaded on control access");

	// ************************************************************
	// mode and pin checks
	// ************************************************************
	a_ctrl_write: assert property (
		ctrlWriteSeq |=> rt.mode == $past(pwdata[2:0]))
		else $error("mode field not taken from the write");

	a_mux4_route: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_MUX4 |->
		cmp1NegLine3 == s_q.ctrl[3] && cmp2NegLine2 == s_q.ctrl[3])
		else $error("input switch routing wrong in mode 010");

	a_reset_mode: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_RESET |->
		!cmp1On && !cmp2On && !posUseVref && rt.analogMask == 5'h0f)
		else $error("reset mode not fully analog and powered down");

	a_off_line: assert property (
		rt.mode == cmp_ctrl_pkg::MODE_OFF |->
		rt.analogMask == 5'h00 && !posUseVref)
		else $error("off mode leaves lines analog");

	// line 4 has no comparator input, so it is always digital
	a_line4_digital: assert property (
		!rt.analogMask[4])
		else $error("line 4 marked as analog input");

	// lines 0..2 never carry comparator levels
	a_port_drive: assert property (
		rt.mode != cmp_ctrl_pkg::MODE_OUTPUTS |-> pinOut == s_q.port)
		else $error("port latch not on pins outside mode 110");

	a_low_lines: assert property (
		pinOut[2:0] == s_q.port[2:0])
		else $error("lines 0 to 2 not driven from the port latch");

	a_pin_enable: assert property (
		pinOe == ~s_q.dir)
		else $error("output enable does not follow direction bits");

endmodule // cmp_ctrl_top

// File: cmp_far_side.sv
`timescale 1ns/10ps
// comparator pair and board wiring beyond the port lines
module cmp_far_side (
	input  wire logic [1:0] cmpSet,
	input  wire logic       cmp1On,
	input  wire logic       cmp2On,
	input  wire logic [4:0] extLevel,
	input  wire logic [4:0] pinOut,
	input  wire logic [4:0] pinOe,
	output logic      [1:0] cmpRawIn,
	output logic      [4:0] pinIn
);
	// a powered-down comparator sits low instead of holding its last level
	assign cmpRawIn = {cmp2On & cmpSet[1], cmp1On & cmpSet[0]};
	// driven lines follow the block, undriven ones the board level
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // cmp_far_side

// File: dual_comparator_control_bench.sv
`timescale 1ns/10ps
module dual_comparator_control_bench;
	localparam logic [11:0] A_CTL  = cmp_ctrl_pkg::ADDR_CMP_CTRL;
	localparam logic [11:0] A_IRQ  = cmp_ctrl_pkg::ADDR_IRQ_CTRL;
	localparam logic [11:0] A_FLAG = cmp_ctrl_pkg::ADDR_FLAG;
	localparam logic [11:0] A_EN   = cmp_ctrl_pkg::ADDR_ENABLE;
	localparam logic [11:0] A_DIR  = cmp_ctrl_pkg::ADDR_DIRECTION;
	localparam logic [11:0] A_PORT = cmp_ctrl_pkg::ADDR_PORT_DATA;
	// analog lines per mode, written out independently of the design
	localparam logic [4:0]  MASKS [8] = '{5'h0f, 5'h0f, 5'h0f, 5'h07,
		5'h0f, 5'h06, 5'h07, 5'h00};
	logic        clk_sys  = 1'b0;
	logic        rst_n    = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0;
	logic [1:0]  cmpSet   = 2'h0;
	logic [4:0]  extLevel = 5'h1f;
	logic        sleepMode = 1'b0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, lastErr;
	logic [1:0]  cmpRawIn;
	logic [4:0]  pinIn, pinOut, pinOe;
	logic        cmp1On, cmp2On, posUseVref, cmp1NegLine3, cmp2NegLine2;
	logic        wakeRequest, irqRequest;
	int          err_total = 0;
	int          checks    = 0;

	// 40 MHz system clock
	always #12.5 clk_sys = ~clk_sys;

	cmp_ctrl_top u_cmp_ctrl_top (.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmpRawIn(cmpRawIn), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .cmp1On(cmp1On), .cmp2On(cmp2On),
		.posUseVref(posUseVref), .cmp1NegLine3(cmp1NegLine3),
		.cmp2NegLine2(cmp2NegLine2), .sleepMode(sleepMode),
		.wakeRequest(wakeRequest), .irqRequest(irqRequest));

	cmp_far_side u_cmp_far_side (.cmpSet(cmpSet), .cmp1On(cmp1On),
		.cmp2On(cmp2On), .extLevel(extLevel), .pinOut(pinOut),
		.pinOe(pinOe), .cmpRawIn(cmpRawIn), .pinIn(pinIn));

	// ************************************************************
	// bus and check helpers
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// entered just after a rising edge; one idle cycle follows each transfer
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d});
	endtask

	task automatic rd(input logic [11:0] a);
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic testReset;
		rd(A_CTL); chk(q, 32'h0);
		rd(A_DIR); chk(q, 32'h1f);
		rd(A_FLAG); chk(q, 32'h0);
		rd(A_EN); chk(q, 32'h0);
		rd(A_PORT); chk(q, 32'h10);
		chk(32'({cmp2On, cmp1On, pinOe}), 32'h0);
		chk(32'({wakeRequest, irqRequest}), 32'h0);
	endtask

	// interrupt enables stay off while modes change
	task automatic testModes;
		logic [2:0] m;
		logic [1:0] pw;
		for (int i = 0; i < 8; i++) begin
			m = i[2:0];
			pw = (m == 3'h0 || m == 3'h7) ? 2'b00 : (m == 3'h5) ? 2'b10 : 2'b11;
			wr(A_CTL, {4'h3, 1'b0, m});
			tick(4); // results may be stale just after a mode change
			rd(A_CTL); chk(q, {29'h0, m});
			rd(A_PORT); chk(q, {27'h0, ~MASKS[i]});
			chk(32'({cmp2On, cmp1On}), 32'(pw));
			chk(32'(posUseVref), 32'(m == 3'h2));
		end
	endtask

	task automatic testRouting;
		for (int s = 0; s < 2; s++) begin
			wr(A_CTL, {4'h0, s[0], 3'h1});
			chk(32'(cmp1NegLine3), 32'(s));
			wr(A_CTL, {4'h0, s[0], 3'h2});
			chk(32'({cmp1NegLine3, cmp2NegLine2}), 32'({s[0], s[0]}));
		end
	endtask

	task automatic testOutputs;
		wr(A_DIR, 8'h07);
		wr(A_CTL, 8'h06);
		wr(A_PORT, 8'h1d);
		cmpSet <= 2'b10;
		tick(1);
		chk(32'({pinOe, pinOut}), 32'h315);
		cmpSet <= 2'b01;
		tick(3); // the pin synchroniser needs two edges before a read
		chk(32'({pinOe, pinOut}), 32'h30d);
		rd(A_PORT); chk(q, 32'h08);
		wr(A_DIR, 8'h1f);
		chk(32'(pinOe), 32'h0);
		cmpSet <= 2'b00;
	endtask

	task automatic testChange;
		wr(A_CTL, 8'hc4);
		tick(4);
		rd(A_CTL); chk(q, 32'h04);
		wr(A_FLAG, 8'h00);
		wr(A_EN, 8'h40);
		wr(A_IRQ, 8'h40);
		cmpSet <= 2'b01;
		tick(4);
		rd(A_FLAG); chk(q, 32'h40);
		chk(32'(irqRequest), 32'h0);
		wr(A_IRQ, 8'hc0); chk(32'(irqRequest), 32'h1);
		wr(A_FLAG, 8'h00);
		rd(A_FLAG); chk(q, 32'h40);
		rd(A_CTL); chk(q, 32'h44);
		wr(A_FLAG, 8'h00);
		rd(A_FLAG); chk(q, 32'h0);
		chk(32'(irqRequest), 32'h0);
		wr(A_FLAG, 8'h40); chk(32'(irqRequest), 32'h1);
		chk(32'(wakeRequest), 32'h0);
		wr(A_FLAG, 8'h00);
	endtask

	task automatic testSleep;
		sleepMode <= 1'b1;
		cmpSet <= 2'b11;
		tick(4);
		chk(32'(wakeRequest), 32'h1);
		rd(A_CTL); chk(q, 32'hc4);
		sleepMode <= 1'b0;
	endtask

	// a reset in mid-run must clear what earlier scenarios left set
	task automatic testMidReset;
		wr(A_DIR, 8'h00);
		rst_n <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		tick(1);
		testReset();
	endtask

	task automatic testUnmapped;
		rd(12'hffc);
		chk(32'(lastErr), 32'h1);
		chk(q, 32'h0);
	endtask

	task automatic print_verdict;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence; reset held for four cycles
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		testReset();
		testModes();
		testRouting();
		testOutputs();
		testChange();
		testSleep();
		testMidReset();
		testUnmapped();
		print_verdict();
	end

	// the run needs well under a thousand cycles; this allows forty thousand
	initial begin
		#1000000;
		err_total++;
		print_verdict();
	end
endmodule // dual_comparator_control_bench
